// ---- pcc_defines.svh ----
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCC_CLK_MHZ          20
`define PCC_DEBOUNCE_US      10000
`define PCC_DEBOUNCE_CYC     (`PCC_DEBOUNCE_US * `PCC_CLK_MHZ)
`define PCC_WIN_PERIODS      512
`define PCC_MIN_PULSES       120

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PCC_OFS_CTRL         8'h00
`define PCC_OFS_STATUS       8'h04
`define PCC_OFS_PCOUNT       8'h08

`define PCC_CTRL_MAKE_MAIN   0
`define PCC_CTRL_INHIBIT     1
`define PCC_RST_CTRL_INH     1'h0

`define PCC_ST_DATA_LOSS     0
`define PCC_ST_AIS           1
`define PCC_ST_GEN_ALARM     2
`define PCC_ST_IN_SERVICE    3
`define PCC_ST_INHIBIT_SW    4
`define PCC_ST_BLOCK_JMP     5
`define PCC_ST_INSERT_JMP    6
`define PCC_ST_INPUT_PRESENT 7
`define PCC_ST_POWER_FAIL    8
`define PCC_ST_HANDSHAKE     9
`define PCC_ST_OUT_DISABLE   10

`define PCC_RESP_OKAY        2'h0
`define PCC_RESP_SLVERR      2'h2

`endif

// ---- pcc_pkg.sv ----
package pcc_pkg;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pcc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pcc_axi_rsp_t;

   typedef enum logic {
      PCC_ROLE_STANDBY,
      PCC_ROLE_MAIN
   } pcc_role_t;

endpackage

// ---- pcc_debounce.sv ----
`timescale 1ns/100ps
`include "pcc_defines.svh"

module pcc_debounce #(
   parameter int   CYCLES  = `PCC_DEBOUNCE_CYC,
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic raw_in,
   output logic      level_out
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(CYCLES - 1);

   logic          sync1_q;
   logic          sync2_q;
   logic [CW-1:0] cnt_q;
   logic          level_q;

   // ----------------------------------------------------------------
   // Two-stage sync, then level must hold for the full count
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= RST_VAL;
         sync2_q <= RST_VAL;
         cnt_q   <= '0;
         level_q <= RST_VAL;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         if (sync2_q == level_q) begin
            cnt_q <= '0;
         end else if (cnt_q == CNT_MAX) begin
            cnt_q   <= '0;
            level_q <= sync2_q;
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
   end

   assign level_out = level_q;

endmodule // pcc_debounce

// ---- pcc_changeover.sv ----
`timescale 1ns/100ps
`include "pcc_defines.svh"

// Functional notes
// - Output jumper fitted disables data output
// - Insert jumper: send alarm signal on loss
// - Block jumper: incoming alarm signal never switches
// - Paired: button requests becoming main
// - Inhibit switch blocks every changeover to main when paired
// - Power-fail bypass closes loss-of-power contact
// - Loss or alarm signal closes general contact
// - Grounded external request makes module main
// - Manager reads alarms, role, switches, jumpers, lock
// - Valid needs 120 pulses per 512 periods
// - All-ones payload sets alarm-signal flag
// - Main selection non-reverting after restore
// - Auto change needs alarmed main partner or no main partner, no inhibit
module pcc_changeover #(
   parameter int DEBOUNCE_CYCLES = `PCC_DEBOUNCE_CYC
) (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_n_in,
   input  wire pcc_pkg::pcc_axi_req_t axi_req_in,
   output pcc_pkg::pcc_axi_rsp_t      axi_rsp_out,
   input  wire logic                  output_disable_jumper_in,
   input  wire logic                  alarm_insert_jumper_in,
   input  wire logic                  alarm_switch_block_jumper_in,
   input  wire logic                  change_request_button_n_in,
   input  wire logic                  change_inhibit_switch_in,
   input  wire logic                  ext_change_request_n_in,
   input  wire logic                  data_pulse_in,
   input  wire logic                  ais_payload_ones_in,
   input  wire logic                  pll_lock_in,
   input  wire logic                  power_fail_in,
   input  wire logic                  handshake_mode_in,
   input  wire logic                  partner_main_in,
   input  wire logic                  partner_alarm_in,
   input  wire logic                  partner_inhibit_in,
   output logic                       data_out_en_out,
   output logic                       ais_insert_out,
   output logic                       in_service_out,
   output logic                       loss_power_contact_out,
   output logic                       general_alarm_contact_out,
   output logic                       alarm_to_partner_out,
   output logic                       inhibit_to_partner_out
);

   localparam int NPIN = 11;
   localparam int P_ODIS = 0;
   localparam int P_AINS = 1;
   localparam int P_ABLK = 2;
   localparam int P_PULSE = 3;
   localparam int P_AIS = 4;
   localparam int P_LOCK = 5;
   localparam int P_PWR = 6;
   localparam int P_HSK = 7;
   localparam int P_PMAIN = 8;
   localparam int P_PALM = 9;
   localparam int P_PINH = 10;
   localparam logic [8:0] WIN_LAST = 9'(`PCC_WIN_PERIODS - 1);
   localparam logic [9:0] MIN_PULSES = 10'(`PCC_MIN_PULSES);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_q;
   logic [2:0]      db_raw;
   logic [2:0]      db_lvl;

   assign pin_raw = {partner_inhibit_in, partner_alarm_in, partner_main_in, handshake_mode_in,
                     power_fail_in, pll_lock_in, ais_payload_ones_in, data_pulse_in,
                     alarm_switch_block_jumper_in, alarm_insert_jumper_in,
                     output_disable_jumper_in};
   assign db_raw  = {ext_change_request_n_in, change_inhibit_switch_in,
                     change_request_button_n_in};

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pin_s1_q <= '0;
         pin_q    <= '0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_q    <= pin_s1_q;
      end
   end

   // Idle levels: button and request released (high), switch at allow (low)
   localparam logic [2:0] DB_IDLE = 3'h5;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_db
         pcc_debounce #(
            .CYCLES  (DEBOUNCE_CYCLES),
            .RST_VAL (DB_IDLE[gi])
         ) u_db (
            .sys_clk_in (sys_clk_in),
            .rst_n_in   (rst_n_in),
            .raw_in     (db_raw[gi]),
            .level_out  (db_lvl[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Input qualification and alarms
   // ----------------------------------------------------------------
   logic [8:0] win_q;
   logic [9:0] pcnt_q;
   logic [9:0] plast_q;
   logic       pulse_prev_q;
   logic       data_loss_q;
   logic       ais_q;
   logic       pulse_rise;
   logic       win_end;
   logic [9:0] pcnt_inc;

   assign pulse_rise = pin_q[P_PULSE] & ~pulse_prev_q;
   assign win_end    = (win_q == WIN_LAST);
   assign pcnt_inc   = (pulse_rise && pcnt_q != 10'h3FF) ? pcnt_q + 10'h001 : pcnt_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         win_q        <= 9'h000;
         pcnt_q       <= 10'h000;
         plast_q      <= 10'h000;
         pulse_prev_q <= 1'b0;
         data_loss_q  <= 1'b1;
         ais_q        <= 1'b0;
      end else begin
         pulse_prev_q <= pin_q[P_PULSE];
         win_q        <= win_q + 9'h001;
         ais_q        <= pin_q[P_AIS];
         if (win_end) begin
            pcnt_q      <= 10'h000;
            plast_q     <= pcnt_inc;
            data_loss_q <= (pcnt_inc < MIN_PULSES);
         end else begin
            pcnt_q <= pcnt_inc;
         end
      end
   end

   // ----------------------------------------------------------------
   // Changeover decision
   // ----------------------------------------------------------------
   pcc_pkg::pcc_role_t role_q;
   pcc_pkg::pcc_role_t role_d;
   logic btn_prev_q;
   logic ext_prev_q;
   logic pmain_prev_q;
   logic ctrl_inh_q;
   logic remote_req_q;
   logic local_alarm;
   logic inhibit_any;
   logic btn_press;
   logic ext_press;
   logic auto_take;
   logic take;
   logic handshake;
   logic partner_took;
   logic [1:0] settle_q;
   logic settled;

   // Synced pins read low until refilled; role holds until then
   assign settled      = (settle_q == 2'h3);

   // Alarm signal may be kept out of switching by the block jumper
   assign local_alarm  = data_loss_q | (ais_q & ~pin_q[P_ABLK]);
   assign inhibit_any  = db_lvl[1] | pin_q[P_PINH] | ctrl_inh_q;
   assign handshake    = pin_q[P_HSK];
   assign btn_press    = ~db_lvl[0] & btn_prev_q;
   assign ext_press    = ~db_lvl[2] & ext_prev_q;
   // Takes over from a main partner only if it is ailing and this module is healthy; always when the partner is not main
   assign auto_take    = (pin_q[P_PMAIN] & pin_q[P_PALM] & ~local_alarm)
                         | ~pin_q[P_PMAIN];
   assign take         = handshake & ~inhibit_any
                         & (btn_press | ext_press | remote_req_q | auto_take);
   assign partner_took = pin_q[P_PMAIN] & ~pmain_prev_q;

   always_comb begin
      role_d = role_q;
      case (role_q)
         pcc_pkg::PCC_ROLE_STANDBY: begin
            // Stays standby once restored; no self return
            if (settled && (!handshake || take)) begin
               role_d = pcc_pkg::PCC_ROLE_MAIN;
            end
         end
         pcc_pkg::PCC_ROLE_MAIN: begin
            if (settled && handshake && partner_took) begin
               role_d = pcc_pkg::PCC_ROLE_STANDBY;
            end
         end
         default: role_d = pcc_pkg::PCC_ROLE_STANDBY;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         role_q       <= pcc_pkg::PCC_ROLE_STANDBY;
         settle_q     <= 2'h0;
         btn_prev_q   <= 1'b1;
         ext_prev_q   <= 1'b1;
         pmain_prev_q <= 1'b0;
      end else begin
         role_q       <= role_d;
         settle_q     <= settled ? settle_q : settle_q + 2'h1;
         btn_prev_q   <= db_lvl[0];
         ext_prev_q   <= db_lvl[2];
         pmain_prev_q <= pin_q[P_PMAIN];
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         data_out_en_out           <= 1'b0;
         ais_insert_out            <= 1'b0;
         in_service_out            <= 1'b0;
         loss_power_contact_out    <= 1'b0;
         general_alarm_contact_out <= 1'b0;
         alarm_to_partner_out      <= 1'b0;
         inhibit_to_partner_out    <= 1'b0;
      end else begin
         data_out_en_out           <= ~pin_q[P_ODIS];
         ais_insert_out            <= pin_q[P_AINS] & data_loss_q;
         in_service_out            <= (role_d == pcc_pkg::PCC_ROLE_MAIN);
         loss_power_contact_out    <= pin_q[P_PWR];
         general_alarm_contact_out <= data_loss_q | ais_q;
         alarm_to_partner_out      <= local_alarm | pin_q[P_PWR];
         inhibit_to_partner_out    <= db_lvl[1] | ctrl_inh_q;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   function automatic logic [1:0] reg_sel(input logic [7:0] addr);
      case (addr)
         `PCC_OFS_CTRL:   reg_sel = 2'h1;
         `PCC_OFS_STATUS: reg_sel = 2'h2;
         `PCC_OFS_PCOUNT: reg_sel = 2'h3;
         default:         reg_sel = 2'h0;
      endcase
   endfunction

   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wstrb0_q;
   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        aw_have;
   logic        w_have;
   logic        do_write;
   logic [1:0]  wsel;
   logic [1:0]  rsel;
   logic [31:0] status_word;
   logic [31:0] rd_word;

   assign aw_take  = axi_req_in.awvalid & awready_q;
   assign w_take   = axi_req_in.wvalid & wready_q;
   assign ar_take  = axi_req_in.arvalid & arready_q;
   assign aw_have  = ~awready_q;
   assign w_have   = ~wready_q;
   assign do_write = aw_have & w_have & ~bvalid_q;
   assign wsel     = reg_sel(awaddr_q);
   assign rsel     = reg_sel(axi_req_in.araddr);

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`PCC_ST_DATA_LOSS]     = data_loss_q;
      status_word[`PCC_ST_AIS]           = ais_q;
      status_word[`PCC_ST_GEN_ALARM]     = general_alarm_contact_out;
      status_word[`PCC_ST_IN_SERVICE]    = in_service_out;
      status_word[`PCC_ST_INHIBIT_SW]    = db_lvl[1];
      status_word[`PCC_ST_BLOCK_JMP]     = pin_q[P_ABLK];
      status_word[`PCC_ST_INSERT_JMP]    = pin_q[P_AINS];
      status_word[`PCC_ST_INPUT_PRESENT] = pin_q[P_LOCK];
      status_word[`PCC_ST_POWER_FAIL]    = pin_q[P_PWR];
      status_word[`PCC_ST_HANDSHAKE]     = handshake;
      status_word[`PCC_ST_OUT_DISABLE]   = pin_q[P_ODIS];
   end

   assign rd_word = (rsel == 2'h1) ? {30'h0000_0000, ctrl_inh_q, 1'b0} :
                    (rsel == 2'h2) ? status_word :
                    (rsel == 2'h3) ? {22'h00_0000, plast_q} : 32'h0000_0000;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         awready_q    <= 1'b1;
         wready_q     <= 1'b1;
         bvalid_q     <= 1'b0;
         bresp_q      <= `PCC_RESP_OKAY;
         arready_q    <= 1'b1;
         rvalid_q     <= 1'b0;
         rdata_q      <= 32'h0000_0000;
         rresp_q      <= `PCC_RESP_OKAY;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb0_q     <= 1'b0;
         ctrl_inh_q   <= `PCC_RST_CTRL_INH;
         remote_req_q <= 1'b0;
      end else begin
         remote_req_q <= 1'b0;
         if (aw_take) begin
            awready_q <= 1'b0;
            awaddr_q  <= axi_req_in.awaddr;
         end
         if (w_take) begin
            wready_q <= 1'b0;
            wdata_q  <= axi_req_in.wdata;
            wstrb0_q <= axi_req_in.wstrb[0];
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == 2'h0) ? `PCC_RESP_SLVERR : `PCC_RESP_OKAY;
            if (wsel == 2'h1 && wstrb0_q) begin
               ctrl_inh_q   <= wdata_q[`PCC_CTRL_INHIBIT];
               remote_req_q <= wdata_q[`PCC_CTRL_MAKE_MAIN];
            end
         end
         if (bvalid_q && axi_req_in.bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
         if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= (rsel == 2'h0) ? `PCC_RESP_SLVERR : `PCC_RESP_OKAY;
         end
         if (rvalid_q && axi_req_in.rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   assign axi_rsp_out = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                          bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                          rdata: rdata_q, rresp: rresp_q};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_output_disable: assert property (
      pin_q[P_ODIS] |=> !data_out_en_out) else $error("output on with jumper fitted");
   chk_ais_insert: assert property (
      data_loss_q && pin_q[P_AINS] |=> ais_insert_out)
      else $error("alarm signal not inserted");
   chk_ais_blocked: assert property (
      ais_q && pin_q[P_ABLK] && !data_loss_q && !pin_q[P_PWR] |=> !alarm_to_partner_out)
      else $error("blocked alarm signal reached partner");
   chk_button_take: assert property (
      btn_press && handshake && !inhibit_any |=> ##1 in_service_out)
      else $error("button did not make module main");
   chk_inhibit_hold: assert property (
      role_q == pcc_pkg::PCC_ROLE_STANDBY && handshake && inhibit_any
      |=> role_q == pcc_pkg::PCC_ROLE_STANDBY) else $error("changeover despite inhibit");
   chk_power_contact: assert property (
      pin_q[P_PWR] [*2] |-> loss_power_contact_out) else $error("power contact open");
   chk_gen_alarm: assert property (
      $rose(data_loss_q) || $rose(ais_q) |=> general_alarm_contact_out)
      else $error("general alarm contact open");
   chk_ext_take: assert property (
      ext_press && handshake && !inhibit_any |=> ##1 in_service_out)
      else $error("external request ignored");
   chk_window_end: assert property (
      $changed(data_loss_q) |-> $past(win_end)) else $error("loss flag moved mid window");
   chk_ais_flag: assert property (
      pin_q[P_AIS] |=> ais_q) else $error("alarm signal flag not set");
   chk_non_revert: assert property (
      role_q == pcc_pkg::PCC_ROLE_STANDBY && handshake && !take
      |=> role_q == pcc_pkg::PCC_ROLE_STANDBY) else $error("standby reverted on its own");
   chk_auto_gate: assert property (
      $rose(in_service_out) && $past(handshake) && !$past(btn_press) && !$past(ext_press)
      && !$past(remote_req_q) |-> !$past(inhibit_any)
      && ($past(pin_q[P_PALM]) || !$past(pin_q[P_PMAIN]))) else $error("auto change gated");

   cov_button_change: cover property (btn_press && handshake ##2 in_service_out);
   cov_auto_change:   cover property (pin_q[P_PMAIN] && pin_q[P_PALM] ##2 $rose(in_service_out));
   cov_loss_rise:     cover property ($rose(data_loss_q));

endmodule // pcc_changeover

// ---- pcc_partner_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Companion module of the redundant pair, changeover side only
// ----------------------------------------------------------------
module pcc_partner_model (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic peer_main_in,
   input  wire logic defect_in,
   input  wire logic inhibit_in,
   input  wire logic take_in,
   output logic      main_out,
   output logic      alarm_out,
   output logic      inhibit_out
);
   logic      peer_main_q;
   logic      main_q;
   wire logic peer_rose = peer_main_in & ~peer_main_q;

   // Starts as main so the block under test must begin in standby
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         main_q      <= 1'b1;
         peer_main_q <= 1'b0;
      end else begin
         peer_main_q <= peer_main_in;
         if (take_in) begin
            main_q <= 1'b1;
         end else if (peer_rose) begin
            main_q <= 1'b0;
         end
      end
   end

   assign main_out    = main_q;
   assign alarm_out   = defect_in;
   assign inhibit_out = inhibit_in;
endmodule // pcc_partner_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "pcc_defines.svh"

module tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                  sys_clk, rst_n;
   pcc_pkg::pcc_axi_req_t req;
   pcc_pkg::pcc_axi_rsp_t rsp;
   logic                  dis_j, ins_j, blk_j, btn_n, inh_sw, ext_n, pulse, ais, pwr, hs;
   logic                  p_main, p_alarm, p_inh, p_def, p_inhsw, p_take;
   logic                  en_o, ais_o, main_o, lp_o, ga_o, al_o, inh_o;
   logic [31:0]           rd, lfsr;
   logic [1:0]            resp;
   int                    gap, pcnt, bad_count, comparisons;

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Gap 4 gives 128 pulses a window, gap 5 only 102 or 103
   always @(posedge sys_clk) begin
      pcnt  <= (pcnt + 1 >= gap) ? 0 : pcnt + 1;
      pulse <= (gap != 0) && (pcnt == 0);
   end

   pcc_changeover #(.DEBOUNCE_CYCLES(4)) i_dut (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .axi_req_in(req), .axi_rsp_out(rsp),
      .output_disable_jumper_in(dis_j), .alarm_insert_jumper_in(ins_j),
      .alarm_switch_block_jumper_in(blk_j), .change_request_button_n_in(btn_n),
      .change_inhibit_switch_in(inh_sw), .ext_change_request_n_in(ext_n),
      .data_pulse_in(pulse), .ais_payload_ones_in(ais), .pll_lock_in(1'b1),
      .power_fail_in(pwr), .handshake_mode_in(hs), .partner_main_in(p_main),
      .partner_alarm_in(p_alarm), .partner_inhibit_in(p_inh), .data_out_en_out(en_o),
      .ais_insert_out(ais_o), .in_service_out(main_o), .loss_power_contact_out(lp_o),
      .general_alarm_contact_out(ga_o), .alarm_to_partner_out(al_o),
      .inhibit_to_partner_out(inh_o));

   pcc_partner_model i_partner (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .peer_main_in(main_o), .defect_in(p_def),
      .inhibit_in(p_inhsw), .take_in(p_take), .main_out(p_main), .alarm_out(p_alarm),
      .inhibit_out(p_inh));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      @(posedge sys_clk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      rd   = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask

   // Long enough to clear both synchroniser and debounce
   task automatic press_btn();
      btn_n <= 1'b0;
      cyc(12);
      btn_n <= 1'b1;
      cyc(12);
   endtask

   task automatic take_over();
      p_take <= 1'b1;
      cyc(1);
      p_take <= 1'b0;
      cyc(10);
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wrap_up();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      wrap_up();
   end

   initial begin
      req = '0;
      {rst_n, dis_j, ins_j, blk_j, inh_sw, ais, pwr, p_def, p_inhsw, p_take} = '0;
      {btn_n, ext_n, hs} = 3'h7;
      {gap, pcnt, bad_count, comparisons} = {32'h4, 96'h0};
      lfsr = 32'h6E05;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(1200);
      cb(ga_o, 1'b0);
      cb(main_o, 1'b0);
      for (int i = 0; i < 8; i++) begin
         dis_j <= i[0];
         ins_j <= i[1];
         blk_j <= i[2];
         cyc(8);
         cb(en_o, !i[0]);
         cb(ais_o, 1'b0);
         axi_rd(`PCC_OFS_STATUS);
         chk({29'h0, rd[10], rd[6], rd[5]}, {29'h0, i[0], i[1], i[2]});
      end
      {dis_j, ins_j} <= 2'h0;
      pwr <= 1'b1;
      cyc(8);
      cb(lp_o, 1'b1);
      cb(al_o, 1'b1);
      pwr <= 1'b0;
      ais <= 1'b1;
      cyc(8);
      cb(lp_o, 1'b0);
      cb(ga_o, 1'b1);
      cb(al_o, 1'b0);
      axi_rd(`PCC_OFS_STATUS);
      cb(rd[1], 1'b1);
      blk_j <= 1'b0;
      cyc(8);
      cb(al_o, 1'b1);
      ais <= 1'b0;
      inh_sw <= 1'b1;
      cyc(12);
      cb(ga_o, 1'b0);
      press_btn();
      cb(main_o, 1'b0);
      cb(inh_o, 1'b1);
      inh_sw <= 1'b0;
      cyc(12);
      press_btn();
      cb(main_o, 1'b1);
      take_over();
      cb(main_o, 1'b0);
      ext_n <= 1'b0;
      cyc(12);
      ext_n <= 1'b1;
      cyc(12);
      cb(main_o, 1'b1);
      take_over();
      {p_inhsw, p_def} <= 2'h3;
      cyc(12);
      cb(main_o, 1'b0);
      p_inhsw <= 1'b0;
      cyc(12);
      cb(main_o, 1'b1);
      p_def <= 1'b0;
      take_over();
      axi_wr(`PCC_OFS_CTRL, 32'h2);
      cyc(6);
      cb(inh_o, 1'b1);
      axi_rd(`PCC_OFS_CTRL);
      chk(rd, 32'h2);
      press_btn();
      cb(main_o, 1'b0);
      axi_wr(`PCC_OFS_CTRL, 32'h0);
      // Remote make-main strobe, a one-cycle request
      axi_wr(`PCC_OFS_CTRL, 32'h1);
      cyc(4);
      cb(main_o, 1'b1);
      take_over();
      ins_j <= 1'b1;
      gap <= 5;
      cyc(1200);
      cb(ga_o, 1'b1);
      cb(ais_o, 1'b1);
      axi_rd(`PCC_OFS_STATUS);
      cb(rd[0], 1'b1);
      ins_j <= 1'b0;
      gap <= 4;
      cyc(8);
      cb(ais_o, 1'b0);
      cyc(1200);
      cb(ga_o, 1'b0);
      // Random unmapped offsets must be refused on both channels
      for (int k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         axi_wr(8'h10 + {2'h0, lfsr[3:0], 2'h0}, lfsr);
         chk({30'h0, resp}, {30'h0, `PCC_RESP_SLVERR});
         axi_rd(8'h10 + {2'h0, lfsr[3:0], 2'h0});
         chk({30'h0, resp}, {30'h0, `PCC_RESP_SLVERR});
      end
      wrap_up();
   end
endmodule // tb_top
